/* File: tkc_pkg.sv */
// Function
// - Hop bit set ignores frequency field
// - Frequency field picks one of eight frequencies
// - Slot clock: reference oscillator or sys/4
// - Reference oscillator runs only when enabled
// - Count sense cycles over slot-clock-derived period
// - Slot overflow stops oscillators and counters
// - Single interrupt at slot overflow; the code also raises irq on count overflows whose mask bits are set
// - Start rising edge begins the measurement
// - Key enables choose touch or I/O
// - Overflow flag sticky until software clears
// - Start low clears counters, keeps slot timer
// - Key select routes one key to oscillator
// - Count clock is sys divided 1/2/4/8
package tkc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;
  localparam logic [3:0] ADDR_CTRL1  = 4'h1;
  localparam logic [3:0] ADDR_TMR    = 4'h2;
  localparam logic [3:0] ADDR_CTL    = 4'h3;
  localparam logic [3:0] ADDR_STAT   = 4'h4;
  localparam logic [3:0] ADDR_MASK   = 4'h5;
  localparam logic [3:0] ADDR_CF_LO  = 4'h6;
  localparam logic [3:0] ADDR_CF_HI  = 4'h7;
  localparam logic [3:0] ADDR_C16_LO = 4'h8;
  localparam logic [3:0] ADDR_C16_HI = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int C0_KSEL_LSB  = 6;
  localparam int C0_HOP       = 3;
  localparam int C1_TSS       = 7;
  localparam int C1_REN       = 5;
  localparam int C1_KEN       = 4;
  localparam int CTL_SLOT_OV  = 6;
  localparam int CTL_START    = 5;
  localparam int CTL_CF_OV    = 4;
  localparam int CTL_C16_OV   = 3;
  localparam int ST_SLOT      = 0;
  localparam int ST_CF        = 1;
  localparam int ST_C16       = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and timing
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam int          SYS_HZ    = 20_000_000;
  localparam int          SLOT_DIV  = 4;
  localparam logic [2:0]  DIV_LAST  = 3'(SLOT_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Whole state of the touch block
  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [7:0]  tmr;
    logic        start;
    logic [1:0]  csel;
    logic [2:0]  stat;
    logic [2:0]  mask;
    logic        running;
    logic [7:0]  slot_tmr;
    logic [4:0]  slot5;
    logic [15:0] cf;
    logic [15:0] c16;
    logic [2:0]  div;
    logic [2:0]  ksync;
    logic [2:0]  rsync;
    logic [2:0]  hop;
    logic [7:0]  rdata;
    logic        ref_run;
    logic        key_run;
    logic [2:0]  freq;
    logic [1:0]  route;
    logic [3:0]  pins;
    logic        irq;
  } tkc_state_s;

  localparam tkc_state_s ST_RESET = '0;

endpackage

/* File: tkc_top.sv */
// The strobed register port and the register offsets were decided locally.
module tkc_top #(
  parameter int NUM_KEYS = 4
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Oscillator clocks from the analog front end
  input  wire logic       key_osc_clk,
  input  wire logic       ref_osc_clk,
  // Analog and pin control
  output logic            ref_osc_run,
  output logic            key_osc_run,
  output logic      [2:0] osc_freq_code,
  output logic      [1:0] key_route,
  output logic      [3:0] touch_pin_sel,
  // Interrupt
  output logic            irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check: the register layout serves four keys only
  generate
    if (NUM_KEYS != 4)
    begin : g_bad_keys
      $error("tkc_top supports exactly four keys");
    end
  endgenerate

  tkc_pkg::tkc_state_s r_reg;
  tkc_pkg::tkc_state_s r_next;

  logic       key_edge;
  logic       ref_edge;
  logic       sys4_tick;
  logic       slot_tick;
  logic       cnt_tick;
  logic       start_rise;
  logic       start_clear;
  logic       slot_last;
  logic       ctl_wr;

  // Write hit on one register index
  function automatic logic wr_hit(input logic [3:0] a);
    wr_hit = reg_wr && (reg_addr == a);
  endfunction

  // Count clock divider taps
  function automatic logic div_tick(input logic [1:0] sel,
                                    input logic [2:0] d);
    case (sel)
      2'b00:   div_tick = 1'b1;
      2'b01:   div_tick = d[0];
      2'b10:   div_tick = &d[1:0];
      default: div_tick = &d;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Events seen by the state update
  // Edges read the second sync stage and its edge history flop, never the first
  assign key_edge    = r_reg.ksync[1] & ~r_reg.ksync[2];
  assign ref_edge    = r_reg.rsync[1] & ~r_reg.rsync[2];
  assign sys4_tick   = (r_reg.div[1:0] == tkc_pkg::DIV_LAST[1:0]);
  assign slot_tick   = r_reg.ctrl1[tkc_pkg::C1_TSS] ? sys4_tick
                                                    : ref_edge;
  assign cnt_tick    = div_tick(r_reg.csel, r_reg.div);
  // A continuous assign wakes on its operands only, so decode here in full
  assign ctl_wr      = reg_wr && (reg_addr == tkc_pkg::ADDR_CTL);
  assign start_rise  = ctl_wr && reg_wdata[tkc_pkg::CTL_START]
                       && !r_reg.start;
  assign start_clear = ctl_wr && !reg_wdata[tkc_pkg::CTL_START];
  assign slot_last   = r_reg.running && slot_tick
                       && (&r_reg.slot_tmr) && (&r_reg.slot5);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [2:0] set_bits;
    logic [2:0] clr_bits;
    set_bits = 3'h0;
    clr_bits = 3'h0;
    r_next   = r_reg;

    // Two-stage synchronisers plus edge history
    r_next.ksync = {r_reg.ksync[1:0], key_osc_clk};
    r_next.rsync = {r_reg.rsync[1:0], ref_osc_clk};
    r_next.div   = r_reg.div + 3'h1;

    // Plain register writes
    if (wr_hit(tkc_pkg::ADDR_CTRL0))
      r_next.ctrl0 = reg_wdata;
    if (wr_hit(tkc_pkg::ADDR_CTRL1))
      r_next.ctrl1 = reg_wdata & 8'hBF;
    if (wr_hit(tkc_pkg::ADDR_TMR))
      r_next.tmr = reg_wdata;
    if (wr_hit(tkc_pkg::ADDR_MASK))
      r_next.mask = reg_wdata[2:0];
    if (wr_hit(tkc_pkg::ADDR_CTL))
    begin
      r_next.start = reg_wdata[tkc_pkg::CTL_START];
      r_next.csel  = reg_wdata[1:0];
    end

    // Measurement: slot timer chained into five-bit slot counter
    if (r_reg.running && slot_tick)
    begin
      if (&r_reg.slot_tmr)
      begin
        r_next.slot_tmr = r_reg.tmr;
        r_next.slot5    = r_reg.slot5 + 5'h01;
      end
      else
        r_next.slot_tmr = r_reg.slot_tmr + 8'h01;
    end

    // Overflow stops everything and raises the one request
    if (slot_last)
    begin
      r_next.running = 1'b0;
      set_bits[tkc_pkg::ST_SLOT] = 1'b1;
    end

    // Sense cycles counted while the window is open
    if (r_reg.running && r_reg.ctrl1[tkc_pkg::C1_KEN] && key_edge)
    begin
      r_next.cf = r_reg.cf + tkc_pkg::CNT_ONE;
      if (r_reg.cf == tkc_pkg::CNT_MAX)
        set_bits[tkc_pkg::ST_CF] = 1'b1;
    end

    // Free count on the divided system clock
    if (r_reg.running && cnt_tick)
    begin
      r_next.c16 = r_reg.c16 + tkc_pkg::CNT_ONE;
      if (r_reg.c16 == tkc_pkg::CNT_MAX)
        set_bits[tkc_pkg::ST_C16] = 1'b1;
    end

    // Start edge restarts the window; counts are held until then unless start is written low
    if (start_rise)
    begin
      r_next.running  = 1'b1;
      r_next.slot_tmr = r_reg.tmr;
      r_next.slot5    = 5'h00;
      r_next.cf       = 16'h0000;
      r_next.c16      = 16'h0000;
      if (r_reg.ctrl0[tkc_pkg::C0_HOP])
        r_next.hop = r_reg.hop + 3'h1;
    end

    // Start written low wins over any count in the same cycle
    if (start_clear)
    begin
      r_next.running  = 1'b0;
      r_next.slot_tmr = r_reg.slot_tmr;
      r_next.cf      = 16'h0000;
      r_next.c16     = 16'h0000;
      r_next.slot5   = 5'h00;
    end

    // Write one to clear; a set in the same cycle wins
    if (wr_hit(tkc_pkg::ADDR_STAT))
      clr_bits = reg_wdata[2:0];
    r_next.stat = (r_reg.stat & ~clr_bits) | set_bits;

    // Registered outputs
    r_next.ref_run = r_next.running
                     && r_next.ctrl1[tkc_pkg::C1_REN];
    r_next.key_run = r_next.running
                     && r_next.ctrl1[tkc_pkg::C1_KEN]
                     && r_next.ctrl1[r_next.ctrl0[7:6]];
    r_next.freq    = r_next.ctrl0[tkc_pkg::C0_HOP] ? r_next.hop
                                                   : r_next.ctrl0[2:0];
    r_next.route   = r_next.ctrl0[tkc_pkg::C0_KSEL_LSB +: 2];
    r_next.pins    = r_next.ctrl1[3:0];
    r_next.irq     = |(r_next.stat & r_next.mask);

    // Read data one cycle after the strobe; unmapped reads zero
    r_next.rdata = tkc_pkg::RST_BYTE;
    if (reg_rd)
    begin
      case (reg_addr)
        tkc_pkg::ADDR_CTRL0:  r_next.rdata = r_reg.ctrl0;
        tkc_pkg::ADDR_CTRL1:  r_next.rdata = r_reg.ctrl1;
        tkc_pkg::ADDR_TMR:    r_next.rdata = r_reg.tmr;
        tkc_pkg::ADDR_CTL:    r_next.rdata = {1'b0,
                                r_reg.stat[tkc_pkg::ST_SLOT], r_reg.start,
                                r_reg.stat[tkc_pkg::ST_CF],
                                r_reg.stat[tkc_pkg::ST_C16], 1'b0,
                                r_reg.csel};
        tkc_pkg::ADDR_STAT:   r_next.rdata = {5'h00, r_reg.stat};
        tkc_pkg::ADDR_MASK:   r_next.rdata = {5'h00, r_reg.mask};
        tkc_pkg::ADDR_CF_LO:  r_next.rdata = r_reg.cf[7:0];
        tkc_pkg::ADDR_CF_HI:  r_next.rdata = r_reg.cf[15:8];
        tkc_pkg::ADDR_C16_LO: r_next.rdata = r_reg.c16[7:0];
        tkc_pkg::ADDR_C16_HI: r_next.rdata = r_reg.c16[15:8];
        default:              r_next.rdata = tkc_pkg::RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      r_reg <= tkc_pkg::ST_RESET;
    else
      r_reg <= r_next;
  end

  // Outputs come straight from state flops
  assign reg_rdata     = r_reg.rdata;
  assign ref_osc_run   = r_reg.ref_run;
  assign key_osc_run   = r_reg.key_run;
  assign osc_freq_code = r_reg.freq;
  assign key_route     = r_reg.route;
  assign touch_pin_sel = r_reg.pins;
  assign irq           = r_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_fixed_freq;
    !r_reg.ctrl0[tkc_pkg::C0_HOP] |-> osc_freq_code == r_reg.ctrl0[2:0];
  endproperty
  a_fixed_freq: assert property (p_fixed_freq)
    else $error("frequency code differs from select field");

  property p_ref_off;
    !r_reg.ctrl1[tkc_pkg::C1_REN] |-> !ref_osc_run;
  endproperty
  a_ref_off: assert property (p_ref_off)
    else $error("reference oscillator runs while disabled");

  property p_key_off;
    !r_reg.ctrl1[tkc_pkg::C1_KEN] |-> !key_osc_run;
  endproperty
  a_key_off: assert property (p_key_off)
    else $error("key oscillator runs while disabled");

  sequence s_overflow;
    slot_last && !start_clear && !start_rise;
  endsequence

  sequence s_stopped;
    !r_reg.running && !ref_osc_run && !key_osc_run
      && r_reg.stat[tkc_pkg::ST_SLOT];
  endsequence

  property p_stop;
    s_overflow |=> s_stopped;
  endproperty
  a_stop: assert property (p_stop)
    else $error("overflow did not stop the measurement");

  property p_irq;
    s_overflow ##1 (r_reg.mask[tkc_pkg::ST_SLOT] && !reg_wr) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked overflow gave no interrupt");

  property p_start;
    start_rise |=> r_reg.running && r_reg.cf == 16'h0000
      && r_reg.slot5 == 5'h00 && r_reg.slot_tmr == $past(r_reg.tmr);
  endproperty
  a_start: assert property (p_start)
    else $error("start edge did not begin a measurement");

  property p_clear;
    start_clear |=> !r_reg.running && r_reg.c16 == 16'h0000
      && r_reg.slot_tmr == $past(r_reg.slot_tmr);
  endproperty
  a_clear: assert property (p_clear)
    else $error("start low did not clear counters as required");

  property p_hold;
    !r_reg.running && !start_rise && !start_clear
      |=> $stable(r_reg.cf) && $stable(r_reg.c16);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count changed while stopped");

  property p_sticky;
    r_reg.stat[tkc_pkg::ST_SLOT]
      && !(reg_wr && reg_addr == tkc_pkg::ADDR_STAT
           && reg_wdata[tkc_pkg::ST_SLOT])
      |=> r_reg.stat[tkc_pkg::ST_SLOT];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("overflow flag dropped without a clear");

  property p_count;
    r_reg.running && r_reg.ctrl1[tkc_pkg::C1_KEN] && key_edge
      && !start_rise && !start_clear
      |=> r_reg.cf == $past(r_reg.cf) + tkc_pkg::CNT_ONE;
  endproperty
  a_count: assert property (p_count)
    else $error("sense edge not counted");

  // Register effects show one edge after the write
  property p_route;
    reg_wr && reg_addr == tkc_pkg::ADDR_CTRL0
      |=> key_route == $past(reg_wdata[7:6]);
  endproperty
  a_route: assert property (p_route)
    else $error("key route does not follow the select field");

  property p_pins;
    reg_wr && reg_addr == tkc_pkg::ADDR_CTRL1
      |=> touch_pin_sel == $past(reg_wdata[3:0]);
  endproperty
  a_pins: assert property (p_pins)
    else $error("pin function does not follow the key enables");

  // Hopping moves the code on every start edge
  property p_hop;
    start_rise && r_reg.ctrl0[tkc_pkg::C0_HOP]
      |=> osc_freq_code == 3'($past(r_reg.hop) + 3'h1);
  endproperty
  a_hop: assert property (p_hop)
    else $error("hopping code did not step on start");

  // Divided clock: slot counters move on every fourth cycle only
  property p_slot_hold;
    r_reg.running && r_reg.ctrl1[tkc_pkg::C1_TSS]
      && r_reg.div[1:0] != tkc_pkg::DIV_LAST[1:0] && !start_clear
      |=> $stable(r_reg.slot_tmr) && $stable(r_reg.slot5);
  endproperty
  a_slot_hold: assert property (p_slot_hold)
    else $error("slot counter moved off the divided clock");

  // Held counts reach the read data one cycle after the strobe
  property p_cf_read;
    reg_rd && reg_addr == tkc_pkg::ADDR_CF_LO
      |=> reg_rdata == $past(r_reg.cf[7:0]);
  endproperty
  a_cf_read: assert property (p_cf_read)
    else $error("count low byte not returned on read");

  // Write one clears the slot flag unless an overflow lands with it
  sequence s_slot_clr;
    reg_wr && reg_addr == tkc_pkg::ADDR_STAT
      && reg_wdata[tkc_pkg::ST_SLOT] && !slot_last;
  endsequence

  property p_w1c;
    s_slot_clr |=> !r_reg.stat[tkc_pkg::ST_SLOT];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("overflow flag not cleared by a written one");

endmodule

/* File: tkc_osc_model.sv */
module tkc_osc_model #(
  parameter int KEY_HALF_NS = 250,
  parameter int REF_HALF_NS = 100
) (
  // Run requests from the block
  input  wire logic key_osc_run,
  input  wire logic ref_osc_run,
  // Oscillator clocks back to the block
  output logic      key_osc_clk,
  output logic      ref_osc_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Both clocks stand low outside a measurement
  initial
  begin
    key_osc_clk = 1'b0;
    ref_osc_clk = 1'b0;
  end

  // Sense pad oscillator, parks low once its run request drops
  always
  begin
    wait (key_osc_run === 1'b1);
    #(KEY_HALF_NS) key_osc_clk = ~key_osc_clk;
    if (key_osc_run !== 1'b1)
      key_osc_clk = 1'b0;
  end

  // Reference oscillator, same parking so no stray slot ticks
  always
  begin
    wait (ref_osc_run === 1'b1);
    #(REF_HALF_NS) ref_osc_clk = ~ref_osc_clk;
    if (ref_osc_run !== 1'b1)
      ref_osc_clk = 1'b0;
  end
endmodule

/* File: testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // Design stimulus and observation
  logic        sys_clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        key_osc_clk;
  logic        ref_osc_clk;
  logic        ref_osc_run;
  logic        key_osc_run;
  logic [2:0]  osc_freq_code;
  logic [1:0]  key_route;
  logic [3:0]  touch_pin_sel;
  logic        irq;
  int          err_count;
  int          comparisons;
  int          n;
  logic [7:0]  d;
  logic [15:0] w;
  logic [2:0]  code;

  ////////////////////////////////////////////////////////////////////////////
  // Block and its oscillators
  tkc_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .key_osc_clk(key_osc_clk),
    .ref_osc_clk(ref_osc_clk), .ref_osc_run(ref_osc_run),
    .key_osc_run(key_osc_run), .osc_freq_code(osc_freq_code),
    .key_route(key_route), .touch_pin_sel(touch_pin_sel), .irq(irq));

  tkc_osc_model u_osc (.key_osc_run(key_osc_run),
    .ref_osc_run(ref_osc_run), .key_osc_clk(key_osc_clk),
    .ref_osc_clk(ref_osc_clk));

  // 20 MHz system clock
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Checking and bus tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Async counts jitter by a few edges, so judge a window
  task automatic rng(input logic [15:0] v, input logic [15:0] lo,
                     input logic [15:0] hi);
    chk({7'h00, v >= lo && v <= hi}, 8'h01);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 4'h1, hi);
    v = {hi, lo};
  endtask

  // Outputs are registered on the same edge as the control registers
  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask

  // Stop, start, check run requests, wait bounded for the interrupt
  task automatic measure(input logic [1:0] sel, input logic [1:0] run,
                         output int cnt);
    wr(tkc_pkg::ADDR_CTL, {6'h00, sel});
    wr(tkc_pkg::ADDR_CTL, {6'h08, sel});
    settle;
    chk({6'h00, ref_osc_run, key_osc_run}, {6'h00, run});
    cnt = 0;
    while (irq !== 1'b1 && cnt < 300)
    begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    tally_and_finish;
  end

  // Main sequence
  initial
  begin
    {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    err_count = 0;
    comparisons = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle;
    chk({irq, ref_osc_run, key_osc_run, osc_freq_code, key_route}, 8'h00);
    rdc(tkc_pkg::ADDR_CTRL1, 8'h00);
    rdc(tkc_pkg::ADDR_CTL, 8'h00);
    rdc(4'hF, 8'h00);
    wr(tkc_pkg::ADDR_CTRL1, 8'hFF);
    rdc(tkc_pkg::ADDR_CTRL1, 8'hBF);
    chk({4'h0, touch_pin_sel}, 8'h0F);
    // Every frequency code and key route
    for (int i = 0; i < 8; i++)
    begin
      d = {i[1:0], 3'b000, i[2:0]};
      wr(tkc_pkg::ADDR_CTRL0, d);
      settle;
      chk({3'h0, key_route, osc_freq_code}, {3'h0, d[7:6], d[2:0]});
    end
    wr(tkc_pkg::ADDR_CTRL0, 8'h04);
    wr(tkc_pkg::ADDR_CTRL1, 8'hB1);
    wr(tkc_pkg::ADDR_TMR, 8'hFF);
    wr(tkc_pkg::ADDR_MASK, 8'h01);
    // Each count clock divider over a 128-cycle window
    for (int s = 0; s < 4; s++)
    begin
      measure(s[1:0], 2'b11, n);
      rng(16'(n), 118, 140);
      chk({6'h00, ref_osc_run, key_osc_run}, 8'h00);
      rd16(tkc_pkg::ADDR_CF_LO, w);
      rng(w, 10, 14);
      rd16(tkc_pkg::ADDR_C16_LO, w);
      rng(w, (16'd128 >> s) - 3, (16'd128 >> s) + 3);
      rdc(tkc_pkg::ADDR_STAT, 8'h01);
      rd(tkc_pkg::ADDR_CTL, d);
      chk(d & 8'h40, 8'h40);
      wr(tkc_pkg::ADDR_STAT, 8'h01);
      settle;
      chk({7'h00, irq}, 8'h00);
    end
    wr(tkc_pkg::ADDR_CTL, 8'h00);
    rd16(tkc_pkg::ADDR_CF_LO, w);
    rng(w, 0, 0);
    rd16(tkc_pkg::ADDR_C16_LO, w);
    rng(w, 0, 0);
    rdc(tkc_pkg::ADDR_TMR, 8'hFF);
    // Key oscillator off and interrupt masked
    wr(tkc_pkg::ADDR_CTRL1, 8'hA1);
    wr(tkc_pkg::ADDR_MASK, 8'h00);
    measure(2'b00, 2'b10, n);
    rng(16'(n), 300, 300);
    rd16(tkc_pkg::ADDR_CF_LO, w);
    rng(w, 0, 0);
    rdc(tkc_pkg::ADDR_STAT, 8'h01);
    wr(tkc_pkg::ADDR_MASK, 8'h01);
    settle;
    chk({7'h00, irq}, 8'h01);
    wr(tkc_pkg::ADDR_STAT, 8'h01);
    // Slot ticks from the reference oscillator
    wr(tkc_pkg::ADDR_CTRL1, 8'h31);
    measure(2'b00, 2'b11, n);
    rng(16'(n), 118, 150);
    wr(tkc_pkg::ADDR_STAT, 8'h01);
    wr(tkc_pkg::ADDR_CTRL1, 8'h11);
    measure(2'b00, 2'b01, n);
    rng(16'(n), 300, 300);
    rdc(tkc_pkg::ADDR_STAT, 8'h00);
    // Hardware hopping steps the code on each start
    wr(tkc_pkg::ADDR_CTRL0, 8'h0F);
    wr(tkc_pkg::ADDR_CTRL1, 8'hB1);
    measure(2'b00, 2'b11, n);
    code = osc_freq_code;
    chk({5'h00, code}, 8'h01);
    wr(tkc_pkg::ADDR_STAT, 8'h01);
    measure(2'b00, 2'b11, n);
    chk({5'h00, osc_freq_code}, {5'h00, code + 3'h1});
    tally_and_finish;
  end
endmodule
